// [verilog/lpm_top.sv]
module lpm_top #(
  parameter int unsigned MS_TICK_CYCLES = lpm_pkg::MS_TICK_CYCLES,
  parameter logic [15:0] SLEEP_MS0 = 16'h03E8,
  parameter logic [15:0] SLEEP_MS1 = 16'h07D0,
  parameter logic [15:0] SLEEP_MS2 = 16'h0BB8,
  parameter logic [15:0] SLEEP_MS3 = 16'h0FA0,
  parameter logic [15:0] WAKE_MS0 = 16'h00A0,
  parameter logic [15:0] WAKE_MS1 = 16'h0190,
  parameter logic [15:0] WAKE_MS2 = 16'h0320,
  parameter logic [15:0] WAKE_MS3 = 16'h0640,
  parameter logic [15:0] LTO_MS0 = 16'h07D0,
  parameter logic [15:0] LTO_MS1 = 16'h0BB8,
  parameter logic [15:0] LTO_MS2 = 16'h0FA0,
  parameter logic [15:0] LTO_MS3 = 16'h1388,
  parameter logic [15:0] DETECT_MS = 16'h01F4,
  parameter logic [15:0] BURST_MS = 16'h0010
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic energy_detect,
  input wire logic flp_loopback,
  input wire logic an_complete,
  input wire logic link_ok,
  output logic flp_special_tx,
  output logic an_run,
  output logic flp_burst_tx,
  output logic pair_b_sel,
  output logic power_down,
  output logic mgmt_interrupt_out
);
  import lpm_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  wire energy_s = sync2_reg[0];
  wire loop_s = sync2_reg[1];
  wire an_done_s = sync2_reg[2];
  wire link_s = sync2_reg[3];

  // Two stages, first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {link_ok, an_complete, flp_loopback, energy_detect};
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // Millisecond tick and random source
  logic [31:0] div_reg;
  logic tick_reg;
  logic [7:0] lfsr_reg;

  // Free divider; LFSR steps every clock so dwell jitter is uncorrelated
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      lfsr_reg <= 8'h01;
    end else begin
      tick_reg <= (div_reg == 32'(MS_TICK_CYCLES - 1));
      div_reg <= (div_reg == 32'(MS_TICK_CYCLES - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  // Field code to duration in ms
  function automatic logic [15:0] pick(input logic [1:0] c, input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] d, input logic [15:0] e);
    unique case (c)
      2'h0: pick = a;
      2'h1: pick = b;
      2'h2: pick = d;
      2'h3: pick = e;
    endcase
  endfunction : pick

  // ==========================================================
  // Registers and APB decode
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic [1:0] det_reg;
  logic link_up_reg;
  logic evt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  lpm_ipd_t ipd_reg;
  lpm_ipd_t ipd_next;
  lpm_pm_t pm_reg;
  lpm_pm_t pm_next;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_reg;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_evt = (paddr == ADDR_EVENT);
  wire mapped = hit_ctrl || hit_stat || hit_evt;
  wire wr_ctrl = access && pwrite && hit_ctrl && !pslverr_reg;
  wire rd_evt = access && !pwrite && hit_evt && !pslverr_reg;
  wire det_en = ctrl_reg[CTRL_DET_EN];
  wire an_en = ctrl_reg[CTRL_AN_EN];
  wire pm_en = ctrl_reg[CTRL_PM_EN];
  wire [1:0] lto_sel = ctrl_reg[CTRL_LTO_LSB +: 2];
  wire [1:0] sleep_sel = ctrl_reg[CTRL_SLEEP_LSB +: 2];
  wire [1:0] wake_sel = ctrl_reg[CTRL_WAKE_LSB +: 2];
  wire [31:0] stat_word = {26'h000_0000, energy_s, pm_reg, link_up_reg, det_reg};
  wire [31:0] rd_word = hit_ctrl ? {23'h00_0000, ctrl_reg} : hit_stat ? stat_word :
                        hit_evt ? {31'h0000_0000, evt_reg} : 32'h0000_0000;

  // Zero-wait slave: data latched in setup, ready and error shown in access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= setup ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Powered-device detection
  logic [15:0] det_ms_reg;
  wire det_seen = (det_reg == DET_NEEDS_PWR);
  wire det_expire = tick_reg && (det_ms_reg >= DETECT_MS - 16'h0001) && !det_seen;
  wire loop_hit = (ipd_reg == IPD_SEARCH) && loop_s && (det_reg == DET_SEARCH);
  wire link_fail = link_up_reg && !link_s;

  // Detection sequencer
  always_comb begin
    ipd_next = ipd_reg;
    unique case (ipd_reg)
      IPD_OFF: if (det_en && an_en) ipd_next = IPD_SEARCH;
      IPD_SEARCH: begin
        if (!det_en || !an_en) ipd_next = IPD_OFF;
        else if (det_expire) ipd_next = IPD_AN;
      end
      IPD_AN: if (link_fail) ipd_next = an_en ? IPD_SEARCH : IPD_OFF;
    endcase
  end

  // Detection timer counts ms while searching
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      det_ms_reg <= 16'h0000;
    end else if (ipd_reg != IPD_SEARCH) begin
      det_ms_reg <= 16'h0000;
    end else if (tick_reg) begin
      det_ms_reg <= det_ms_reg + 16'h0001;
    end
  end

  // Control word: hardware clear on timeout, hardware set on link failure
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
      if (ipd_reg == IPD_SEARCH && det_expire) ctrl_reg[CTRL_DET_EN] <= 1'b0;
      if (ipd_reg == IPD_AN && link_fail) ctrl_reg[CTRL_DET_EN] <= 1'b1;
    end
  end

  // Detection status, link bit and sticky event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ipd_reg <= IPD_OFF;
      det_reg <= DET_SEARCH;
      link_up_reg <= 1'b0;
      evt_reg <= 1'b0;
      flp_special_tx <= 1'b0;
      an_run <= 1'b0;
      mgmt_interrupt_out <= 1'b0;
    end else begin
      ipd_reg <= ipd_next;
      if (ipd_reg == IPD_OFF && ipd_next == IPD_SEARCH) det_reg <= DET_SEARCH;
      else if (ipd_reg == IPD_AN && ipd_next != IPD_AN) det_reg <= DET_SEARCH;
      else if (loop_hit) det_reg <= DET_NEEDS_PWR;
      else if (ipd_reg == IPD_SEARCH && det_expire) det_reg <= DET_TIMEOUT;
      link_up_reg <= (ipd_next == IPD_AN) && an_done_s && link_s;
      // Set wins over the clear-on-read
      evt_reg <= loop_hit || (evt_reg && !rd_evt);
      mgmt_interrupt_out <= loop_hit || (evt_reg && !rd_evt);
      flp_special_tx <= (ipd_next == IPD_SEARCH);
      an_run <= (ipd_next == IPD_AN);
    end
  end

  // ==========================================================
  // Power manager
  logic [15:0] pm_ms_reg;
  logic [15:0] dwell_reg;
  logic [15:0] burst_ms_reg;
  logic [1:0] burst_cnt_reg;
  wire [7:0] r_raw = lfsr_reg;
  wire [7:0] r_mod = (r_raw >= 8'(RAND_SPAN)) ? r_raw - 8'(RAND_SPAN) : r_raw;
  // Sleep codes below 80 ms would underflow; parameters must stay above it
  wire [15:0] sleep_rand = pick(sleep_sel, SLEEP_MS0, SLEEP_MS1, SLEEP_MS2, SLEEP_MS3)
                           - 16'(RAND_NEG_MS) + {8'h00, r_mod};
  wire [15:0] wake_ms = pick(wake_sel, WAKE_MS0, WAKE_MS1, WAKE_MS2, WAKE_MS3);
  wire [15:0] lto_ms = pick(lto_sel, LTO_MS0, LTO_MS1, LTO_MS2, LTO_MS3);
  wire pm_expire = tick_reg && (pm_ms_reg + 16'h0001 >= dwell_reg);
  wire burst_end = tick_reg && (burst_ms_reg + 16'h0001 >= BURST_MS);
  wire bursts_done = (burst_cnt_reg == 2'(WAKE_BURSTS));

  // State transitions
  always_comb begin
    pm_next = pm_reg;
    unique case (pm_reg)
      PM_LOW: begin
        if (!pm_en || energy_s) pm_next = PM_NORMAL;
        else if (pm_expire) pm_next = PM_WAKE;
      end
      PM_WAKE: begin
        if (!pm_en || energy_s) pm_next = PM_NORMAL;
        else if (pm_expire || (bursts_done && burst_ms_reg == 16'h0000)) pm_next = PM_LOW;
      end
      PM_NORMAL: if (pm_en && an_en && !link_s) pm_next = PM_LINKWAIT;
      PM_LINKWAIT: begin
        if (!pm_en || !an_en || link_s) pm_next = PM_NORMAL;
        else if (pm_expire) pm_next = PM_LOW;
      end
    endcase
  end

  // Dwell timer reloads on each state change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pm_reg <= PM_LOW;
      pm_ms_reg <= 16'h0000;
      dwell_reg <= SLEEP_MS1;
    end else begin
      pm_reg <= pm_next;
      if (pm_next != pm_reg) begin
        pm_ms_reg <= 16'h0000;
        unique case (pm_next)
          PM_LOW: dwell_reg <= sleep_rand;
          PM_WAKE: dwell_reg <= wake_ms;
          PM_LINKWAIT: dwell_reg <= lto_ms;
          PM_NORMAL: dwell_reg <= 16'hFFFF;
        endcase
      end else if (tick_reg) begin
        pm_ms_reg <= pm_ms_reg + 16'h0001;
      end
    end
  end

  // Wake-up bursts alternate pairs; at most three per wake-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burst_ms_reg <= 16'h0000;
      burst_cnt_reg <= 2'h0;
      flp_burst_tx <= 1'b0;
      pair_b_sel <= 1'b0;
      power_down <= 1'b1;
    end else begin
      if (pm_next != PM_WAKE) begin
        burst_ms_reg <= 16'h0000;
        burst_cnt_reg <= 2'h0;
        pair_b_sel <= 1'b0;
      end else if (pm_reg == PM_WAKE && !bursts_done && burst_end) begin
        burst_ms_reg <= 16'h0000;
        burst_cnt_reg <= burst_cnt_reg + 2'h1;
        pair_b_sel <= !pair_b_sel;
      end else if (pm_reg == PM_WAKE && !bursts_done && tick_reg) begin
        burst_ms_reg <= burst_ms_reg + 16'h0001;
      end
      flp_burst_tx <= (pm_next == PM_WAKE) && !(bursts_done || (burst_cnt_reg == 2'h2 && burst_end));
      power_down <= (pm_next == PM_LOW);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================
  // Checks
  property p_det_enter;
    @(posedge clk) disable iff (!rst_n) (ipd_reg == IPD_OFF && det_en && an_en) |=> ipd_reg == IPD_SEARCH;
  endproperty
  a_det_enter: assert property (p_det_enter) else $error("detection not entered");

  property p_flp_tx;
    @(posedge clk) disable iff (!rst_n) flp_special_tx == (ipd_reg == IPD_SEARCH);
  endproperty
  a_flp_tx: assert property (p_flp_tx) else $error("special pulses mismatch");

  property p_loop;
    @(posedge clk) disable iff (!rst_n) loop_hit |=> det_reg == DET_NEEDS_PWR && evt_reg && mgmt_interrupt_out;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not reported");

  property p_rd_clear;
    @(posedge clk) disable iff (!rst_n) (rd_evt && !loop_hit) |=> !evt_reg && !mgmt_interrupt_out;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("event not cleared by read");

  property p_timeout;
    @(posedge clk) disable iff (!rst_n) (ipd_reg == IPD_SEARCH && det_en && an_en && det_expire && !loop_hit)
      |=> det_reg == DET_TIMEOUT && !det_en ##1 an_run;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not hand over");

  property p_link_fail;
    @(posedge clk) disable iff (!rst_n) (ipd_reg == IPD_AN && link_fail && an_en) |=> !link_up_reg && det_en
      ##1 !an_run && flp_special_tx;
  endproperty
  a_link_fail: assert property (p_link_fail) else $error("link failure not handled");

  property p_energy;
    @(posedge clk) disable iff (!rst_n) ((pm_reg == PM_LOW || pm_reg == PM_WAKE) && energy_s) |=> pm_reg == PM_NORMAL;
  endproperty
  a_energy: assert property (p_energy) else $error("energy ignored");

  property p_stay_normal;
    @(posedge clk) disable iff (!rst_n) (pm_reg == PM_NORMAL && !an_en) |=> pm_reg == PM_NORMAL;
  endproperty
  a_stay_normal: assert property (p_stay_normal) else $error("left normal without autoneg");

  property p_reset_low;
    @(posedge clk) $rose(rst_n) |-> pm_reg == PM_LOW && power_down;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("not low power after reset");

  property p_pdown;
    @(posedge clk) disable iff (!rst_n) power_down == (pm_reg == PM_LOW);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down mismatch");

  property p_bursts;
    @(posedge clk) disable iff (!rst_n) bursts_done |-> !flp_burst_tx;
  endproperty
  a_bursts: assert property (p_bursts) else $error("burst sent after the last one");
endmodule : lpm_top

// [verilog/lpm_pkg.sv]
package lpm_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned RAND_NEG_MS = 80;
  localparam int unsigned RAND_POS_MS = 60;
  localparam int unsigned RAND_SPAN = RAND_NEG_MS + RAND_POS_MS + 1;
  localparam int unsigned WAKE_BURSTS = 3;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  // Control fields
  localparam int CTRL_DET_EN = 0;
  localparam int CTRL_AN_EN = 1;
  localparam int CTRL_PM_EN = 2;
  localparam int CTRL_LTO_LSB = 3;
  localparam int CTRL_SLEEP_LSB = 5;
  localparam int CTRL_WAKE_LSB = 7;
  localparam int CTRL_WIDTH = 9;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h002;
  // Status fields
  localparam int STAT_DET_LSB = 0;
  localparam int STAT_LINK = 2;
  localparam int STAT_PM_LSB = 3;
  localparam int STAT_ENERGY = 5;
  // Event fields
  localparam int EVT_DETECT = 0;
  // Detection status codes
  localparam logic [1:0] DET_SEARCH = 2'h0;
  localparam logic [1:0] DET_NEEDS_PWR = 2'h1;
  localparam logic [1:0] DET_TIMEOUT = 2'h2;
  // ==========================================================
  // States
  typedef enum logic [1:0] {IPD_OFF, IPD_SEARCH, IPD_AN} lpm_ipd_t;
  typedef enum logic [1:0] {PM_LOW, PM_WAKE, PM_NORMAL, PM_LINKWAIT} lpm_pm_t;
endpackage : lpm_pkg

// [bench/lpm_partner.sv]
// ==========================================================
// Cable-side partner: powered device echo and link bring-up
module lpm_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flp_special_tx,
  input wire logic an_run,
  input wire logic loop_en,
  input wire logic link_en,
  output logic flp_loopback,
  output logic an_complete,
  output logic link_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] an_cnt_reg;
  // Unpowered device echoes pulses; link needs some negotiation time, not instant
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flp_loopback <= 1'b0;
      an_cnt_reg <= 4'h0;
    end else begin
      flp_loopback <= flp_special_tx & loop_en;
      an_cnt_reg <= (an_run & link_en) ? an_cnt_reg + {3'h0, an_cnt_reg != 4'hF} : 4'h0;
    end
  end
  assign an_complete = an_cnt_reg == 4'hF;
  assign link_ok = an_complete & link_en;
endmodule : lpm_partner

// [bench/lpm_top_tb.sv]
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module lpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, energy_detect, loop_en, link_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, m_v;
  logic [32:0] e_v;
  logic pready, pslverr, flp_loopback, an_complete, link_ok, flp_special_tx, an_run;
  logic flp_burst_tx, pair_b_sel, power_down, mgmt_interrupt_out, pt, pp, lp;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n, b;
  // ==========================================================
  // Design and partner; tick and link timeouts shrunk, sleep, wake and detection keep defaults
  lpm_top #(.MS_TICK_CYCLES(10), .LTO_MS0(16'h000A), .LTO_MS1(16'h0014), .LTO_MS2(16'h001E),
    .LTO_MS3(16'h0028)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .energy_detect(energy_detect), .flp_loopback(flp_loopback),
    .an_complete(an_complete), .link_ok(link_ok), .flp_special_tx(flp_special_tx), .an_run(an_run),
    .flp_burst_tx(flp_burst_tx), .pair_b_sel(pair_b_sel), .power_down(power_down),
    .mgmt_interrupt_out(mgmt_interrupt_out));
  lpm_partner partner_u (.clk(clk), .rst_n(rst_n), .flp_special_tx(flp_special_tx), .an_run(an_run),
    .loop_en(loop_en), .link_en(link_en), .flp_loopback(flp_loopback), .an_complete(an_complete),
    .link_ok(link_ok));
  // ==========================================================
  // Clock, timeout and read monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  // Read data taken at the rising edge where the master sees pready high
  always @(posedge clk) begin
    if (rst_n && psel && penable && pready && !pwrite) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      `CHK({pslverr, prdata & m_v}, e_v)
    end
  end
  // ==========================================================
  // Tasks
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Request held until pready is seen high at a rising edge
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({err, e & m});
    msk_q.push_back(m);
    apb(1'b0, a, rnd());
  endtask : rd
  task automatic wr_ctrl(input logic [8:0] c);
    logic [31:0] r;
    r = rnd();
    apb(1'b1, ADDR_CTRL, {r[31:9], c});
  endtask : wr_ctrl
  task automatic wait_pd(input logic v);
    n = 0;
    @(negedge clk);
    while (power_down !== v && n < 12000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : wait_pd
  task automatic do_reset();
    rst_n <= 1'b0;
    energy_detect <= 1'b0;
    loop_en <= 1'b0;
    link_en <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(power_down, 1'b1)
    @(posedge clk);
  endtask : do_reset
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h0001_5E5B;
    {rst_n, psel, penable, pwrite, energy_detect, loop_en, link_en} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    do_reset();
    rd(ADDR_CTRL, 1'b0, 32'h0000_0002, 32'hFFFF_FFFF);
    rd(ADDR_EVENT, 1'b0, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ADDR_CTRL, 1'b0, 32'h0000_0002, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 1'b0, 32'h0000_0010, 32'h0000_001F);
    $display("Register test done");
    // Detection of a device that needs power
    wr_ctrl(9'h003);
    repeat (4) @(posedge clk);
    `CHK(flp_special_tx, 1'b1)
    rd(ADDR_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0003);
    loop_en <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(mgmt_interrupt_out, 1'b1)
    rd(ADDR_STATUS, 1'b0, 32'h0000_0001, 32'h0000_0003);
    rd(ADDR_EVENT, 1'b0, 32'h0000_0001, 32'h0000_0001);
    loop_en <= 1'b0; // Power applied outside, device stops echoing
    @(posedge clk);
    `CHK(mgmt_interrupt_out, 1'b0)
    rd(ADDR_EVENT, 1'b0, 32'h0000_0000, 32'h0000_0001);
    $display("Detection test done");
    // Detection timeout, autonegotiation and link loss
    do_reset();
    wr_ctrl(9'h003);
    n = 0;
    while (an_run !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n inside {[4980:5030]}, 1'b1)
    rd(ADDR_STATUS, 1'b0, 32'h0000_0002, 32'h0000_0003);
    rd(ADDR_CTRL, 1'b0, 32'h0000_0002, 32'h0000_01FF);
    link_en <= 1'b1;
    repeat (24) @(posedge clk);
    rd(ADDR_STATUS, 1'b0, 32'h0000_0004, 32'h0000_0004);
    link_en <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADDR_CTRL, 1'b0, 32'h0000_0003, 32'h0000_01FF);
    `CHK({flp_special_tx, an_run}, 2'b10)
    $display("Autonegotiation test done");
    // Power manager: sleep dwell, wake bursts, energy and timeouts
    do_reset();
    wr_ctrl(9'h006);
    wait_pd(1'b1);
    rd(ADDR_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0018);
    for (int k = 0; k < 2; k++) begin
      wait_pd(1'b0);
      `CHK(n inside {[9150:10650]}, 1'b1)
      {b, n, pt, pp} = 0;
      while (power_down === 1'b0 && n < 1000) begin
        @(negedge clk);
        if (flp_burst_tx === 1'b1 && (!pt || pair_b_sel !== pp)) begin
          if (b > 0) `CHK(pair_b_sel, ~lp)
          lp = pair_b_sel;
          b++;
        end
        pt = flp_burst_tx;
        pp = pair_b_sel;
        n++;
      end
      `CHK(b, 3)
      `CHK(n inside {[440:520]}, 1'b1)
      @(posedge clk);
    end
    for (int c = 0; c < 4; c++) begin
      wr_ctrl({4'h0, c[1:0], 3'b110});
      wait_pd(1'b1);
      energy_detect <= 1'b1;
      wait_pd(1'b0);
      `CHK(n < 6, 1'b1)
      energy_detect <= 1'b0;
      wait_pd(1'b1);
      `CHK(n inside {[(c + 1) * 100 - 20:(c + 1) * 100 + 20]}, 1'b1)
    end
    wr_ctrl(9'h004);
    energy_detect <= 1'b1;
    wait_pd(1'b0);
    energy_detect <= 1'b0;
    repeat (600) @(posedge clk);
    `CHK(power_down, 1'b0)
    rd(ADDR_STATUS, 1'b0, 32'h0000_0010, 32'h0000_0018);
    $display("Power manager test done");
    give_verdict();
  end
endmodule : lpm_top_tb
